// ---- saeis_pkg.sv ----
// Package for the sleep controller and external interrupt sense block.
// Assumes a single system clock; every other file but the core model refers to these names with saeis_pkg:: prefixes.
package saeis_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the plain register port.
  localparam logic [7:0] MCU_CTRL_OFS = 8'h35;
  localparam logic [7:0] MCU_CTRL_EXT_OFS = 8'h36;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h40;
  localparam logic [7:0] IRQ_FLAG_OFS = 8'h41;
  localparam logic [7:0] SLEEP_STAT_OFS = 8'h42;

  // Reset values.
  localparam logic [7:0] MCU_CTRL_RST = 8'h00;
  localparam logic [7:0] MCU_CTRL_EXT_RST = 8'h00;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [2:0] IRQ_FLAG_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in mcu_control.
  localparam int unsigned SLEEP_ENABLE_BIT = 5;
  localparam int unsigned SLEEP_MODE_HI_BIT = 4;
  localparam int unsigned EXT_IRQ_PIN_B_SENSE_LSB = 2;
  localparam int unsigned EXT_IRQ_PIN_A_SENSE_LSB = 0;
  // Field positions in mcu_control_extended.
  localparam int unsigned SLEEP_MODE_LO_BIT = 7;
  localparam int unsigned EXT_IRQ_PIN_C_EDGE_SELECT_BIT = 0;
  // Bit of each pin in the mask and flag registers.
  localparam int unsigned PIN_A_IDX = 0;
  localparam int unsigned PIN_B_IDX = 1;
  localparam int unsigned PIN_C_IDX = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Timing counts.
  localparam int unsigned WAKE_HALT_CYC = 4;
  localparam logic [1:0] WDT_LEVEL_SAMPLES = 2'h2;
  localparam int unsigned CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Sense selection for the first and second pins.
  typedef enum logic [1:0] {
    SAEIS_SENSE_LOW = 2'h0,
    SAEIS_SENSE_ANY = 2'h1,
    SAEIS_SENSE_FALL = 2'h2,
    SAEIS_SENSE_RISE = 2'h3
  } saeis_sense_t;

  // Decoded sleep mode.
  typedef enum logic [1:0] {
    SAEIS_MODE_IDLE = 2'h0,
    SAEIS_MODE_PDOWN = 2'h2,
    SAEIS_MODE_PSAVE = 2'h3
  } saeis_mode_t;

  // Sequencer states, Gray coded along run, sleep, wake delay, halt.
  typedef enum logic [1:0] {
    SAEIS_ST_RUN = 2'h0,
    SAEIS_ST_SLEEP = 2'h1,
    SAEIS_ST_WAKE_DLY = 2'h3,
    SAEIS_ST_HALT = 2'h2
  } saeis_state_t;

  // Clock gate enables driven to the clock tree.
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic t2_clk_en;
  } saeis_gate_t;

  // Timer 2 state seen by the wake logic.
  typedef struct packed {
    logic async_sel;
    logic ovf_flag;
    logic ovf_en;
    logic cmp_flag;
    logic cmp_en;
  } saeis_t2_t;

endpackage

// ---- saeis_core.sv ----
// Sleep sequencer, clock gating and external interrupt sense logic of the microcontroller.
// Assumes all inputs, including the pins and the watchdog oscillator level, are synchronous to clk_sys_in.
//
// Contract
// [R1] Sleep instruction enters sleep only while sleep_enable is one.
// [R2] Software sets sleep_enable right before the sleep instruction.
// [R3] Mode bits 00 idle, 01 reserved, 10 power-down, 11 power-save.
// [R4] ext_irq_pin_b_sense selects low, any change, falling or rising on pin b.
// [R5] ext_irq_pin_a_sense selects low, any change, falling or rising on pin a.
// [R6] Pins a and b are sampled before edge detection.
// [R7] Source holds a low level until the current instruction completes.
// [R8] Request taken only when global flag and pin mask are set.
// [R9] ext_irq_pin_c_edge_select chooses falling or rising edge on pin c; no level mode.
// [R10] Pin c edges are captured; pulses above 50 ns give a request.
// [R11] Software masks pin c, changes edge select, clears flag, re-enables.
// [R12] Interrupt wake halts CPU four cycles, then runs the handler.
// [R13] Sleep keeps memory contents; reset during sleep wakes to reset vector.
// [R14] Idle stops only the CPU clock; peripherals and interrupts keep running.
// [R15] Power-down stops oscillator; only reset, level a/b or edge c wake.
// [R16] A pin c edge used to leave power-down stays latched until wake.
// [R17] Level wake needs the level at two successive watchdog samples.
// [R18] Power-down wake waits a delay chosen by clock_select_fuses.
// [R19] Vanished wake condition still wakes but its interrupt is not run.
// [R20] Power-save keeps async timer 2 running; its enabled events wake.
// [R21] Without async timer 2, software uses power-down, not power-save.
// [R22] Pins raise requests even when their port drives them as outputs.
// [R23] Reserved mode encoding 01 acts as idle.
`timescale 1ns/100ps

module saeis_core #(
  parameter int unsigned WAKE_UNIT_CYC = 16
) (
  // Clock, reset and clock enable.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Register port.
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Processor core.
  input wire logic sleep_instr_in,
  input wire logic global_irq_en_in,
  input wire logic [2:0] irq_ack_in,
  input wire logic periph_irq_in,
  output logic [2:0] irq_req_out,
  output logic sleeping_out,
  // External pins and wake sources.
  input wire logic ext_irq_pin_a_in,
  input wire logic ext_irq_pin_b_in,
  input wire logic ext_irq_pin_c_in,
  input wire logic wdt_osc_in,
  input wire logic [3:0] clock_select_fuses_in,
  input wire saeis_pkg::saeis_t2_t timer2_in,
  // Clock gating.
  output saeis_pkg::saeis_gate_t gate_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [7:0] mcu_control_r;
  logic [7:0] mcu_control_extended_r;
  logic [2:0] irq_mask_r;
  logic [2:0] irq_flag_r;
  logic [2:0] irq_flag_nxt;
  logic [2:0] pin_q_r;
  logic wdt_q_r;
  logic [1:0] lvl_cnt_r;
  logic [1:0] lvl_cnt_nxt;
  logic [saeis_pkg::CNT_W-1:0] cnt_r;
  logic [saeis_pkg::CNT_W-1:0] cnt_nxt;
  saeis_pkg::saeis_state_t state_r;
  saeis_pkg::saeis_state_t state_nxt;
  saeis_pkg::saeis_mode_t mode_r;
  saeis_pkg::saeis_gate_t gate_nxt;
  logic [7:0] rdata_r;
  logic [2:0] irq_req_r;
  logic sleeping_r;

  wire [2:0] pin_now = {ext_irq_pin_c_in, ext_irq_pin_b_in, ext_irq_pin_a_in};
  wire [2:0] pin_rise = pin_now & ~pin_q_r;
  wire [2:0] pin_fall = ~pin_now & pin_q_r;
  wire [1:0] edge_evt;
  wire [1:0] level_act;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  wire wr_ctrl = reg_wr_in && (reg_addr_in == saeis_pkg::MCU_CTRL_OFS);
  wire wr_ctrl_ext = reg_wr_in && (reg_addr_in == saeis_pkg::MCU_CTRL_EXT_OFS);
  wire wr_mask = reg_wr_in && (reg_addr_in == saeis_pkg::IRQ_MASK_OFS);
  wire wr_flag = reg_wr_in && (reg_addr_in == saeis_pkg::IRQ_FLAG_OFS);

  // Control fields.
  wire sleep_enable = mcu_control_r[saeis_pkg::SLEEP_ENABLE_BIT];
  wire sleep_mode_hi = mcu_control_r[saeis_pkg::SLEEP_MODE_HI_BIT];
  wire sleep_mode_lo = mcu_control_extended_r[saeis_pkg::SLEEP_MODE_LO_BIT];
  wire ext_irq_pin_c_edge_select = mcu_control_extended_r[saeis_pkg::EXT_IRQ_PIN_C_EDGE_SELECT_BIT];
  wire [1:0] ext_irq_pin_a_sense = mcu_control_r[saeis_pkg::EXT_IRQ_PIN_A_SENSE_LSB +: 2];
  wire [1:0] ext_irq_pin_b_sense = mcu_control_r[saeis_pkg::EXT_IRQ_PIN_B_SENSE_LSB +: 2];
  wire [3:0] sense_pair = {ext_irq_pin_b_sense, ext_irq_pin_a_sense};

  // Mode decode; the reserved encoding falls back to idle so sleep is always defined.
  wire saeis_pkg::saeis_mode_t mode_sel =
    !sleep_mode_hi ? saeis_pkg::SAEIS_MODE_IDLE : // R3 R23
    (sleep_mode_lo ? saeis_pkg::SAEIS_MODE_PSAVE : saeis_pkg::SAEIS_MODE_PDOWN); // R3

  // Read mux; unmapped offsets read as zero.
  wire [7:0] stat_word = {2'h0, mode_r, 2'h0, state_r};
  wire [7:0] rd_mux =
    (reg_addr_in == saeis_pkg::MCU_CTRL_OFS) ? mcu_control_r :
    (reg_addr_in == saeis_pkg::MCU_CTRL_EXT_OFS) ? mcu_control_extended_r :
    (reg_addr_in == saeis_pkg::IRQ_MASK_OFS) ? {5'h00, irq_mask_r} :
    (reg_addr_in == saeis_pkg::IRQ_FLAG_OFS) ? {5'h00, irq_flag_r} :
    (reg_addr_in == saeis_pkg::SLEEP_STAT_OFS) ? stat_word : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Edge and level sense for pins a and b, comparing each sample with the previous one.
  // The pin level is looked at directly, never through the port direction, so software can drive it.
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sense
      wire [1:0] sel = sense_pair[2*i +: 2];
      assign edge_evt[i] =
        (sel == saeis_pkg::SAEIS_SENSE_ANY) ? (pin_rise[i] | pin_fall[i]) : // R4 R5 R6 R22
        (sel == saeis_pkg::SAEIS_SENSE_FALL) ? pin_fall[i] : // R4 R5 R6
        (sel == saeis_pkg::SAEIS_SENSE_RISE) ? pin_rise[i] : 1'b0; // R4 R5 R6
      assign level_act[i] = (sel == saeis_pkg::SAEIS_SENSE_LOW) && !pin_now[i]; // R4 R5
    end
  endgenerate

  // Pin c has edges only; at 4 ns per sample any pulse wider than 50 ns is seen at least
  // twelve times, so no separate asynchronous latch is needed here.
  wire ext_irq_pin_c_evt = ext_irq_pin_c_edge_select ? pin_rise[saeis_pkg::PIN_C_IDX] : pin_fall[saeis_pkg::PIN_C_IDX]; // R9 R10

  // Flags: an edge in the same cycle as a clear keeps the flag set.
  wire [2:0] flag_set = {ext_irq_pin_c_evt, edge_evt};
  wire [2:0] flag_clr = (wr_flag ? reg_wdata_in[2:0] : 3'h0) | irq_ack_in;
  assign irq_flag_nxt = (irq_flag_r & ~flag_clr) | flag_set; // R16

  // Pending and enabled requests; a level request lasts only while the pin stays low.
  wire [2:0] pend = irq_flag_r | {1'b0, level_act};
  wire [2:0] en_pend = pend & irq_mask_r & {3{global_irq_en_in}}; // R8

  ////////////////////////////////////////////////////////////////////////////
  // Level wake qualification on the watchdog oscillator: two successive sampling
  // points must both see the enabled low level, which rejects short noise.
  wire wdt_tick = wdt_osc_in && !wdt_q_r;
  wire lvl_en = |(level_act & irq_mask_r[1:0]) && global_irq_en_in;
  wire lvl_wake = (lvl_cnt_r == saeis_pkg::WDT_LEVEL_SAMPLES); // R17
  always_comb begin
    lvl_cnt_nxt = lvl_cnt_r;
    if (state_r != saeis_pkg::SAEIS_ST_SLEEP) begin
      lvl_cnt_nxt = 2'h0;
    end else if (wdt_tick) begin
      if (!lvl_en) begin
        lvl_cnt_nxt = 2'h0; // R17
      end else if (!lvl_wake) begin
        lvl_cnt_nxt = lvl_cnt_r + 2'h1; // R17
      end
    end
  end

  // Wake sources for each mode.
  wire t2_wake = timer2_in.async_sel && global_irq_en_in &&
    ((timer2_in.ovf_flag && timer2_in.ovf_en) || (timer2_in.cmp_flag && timer2_in.cmp_en)); // R20
  wire wake_idle = |en_pend || periph_irq_in; // R14
  wire wake_pd = lvl_wake || en_pend[saeis_pkg::PIN_C_IDX]; // R15 R16
  wire wake_ps = wake_pd || t2_wake; // R20

  // Wake delay from the fuses; the sum is at most sixteen units.
  wire [saeis_pkg::CNT_W-1:0] wake_units = {{(saeis_pkg::CNT_W-4){1'b0}}, clock_select_fuses_in};
  wire [saeis_pkg::CNT_W-1:0] wake_dly_cyc =
    saeis_pkg::CNT_W'(WAKE_UNIT_CYC) * (wake_units + saeis_pkg::CNT_W'(1)); // R18
  wire [saeis_pkg::CNT_W-1:0] halt_last = saeis_pkg::CNT_W'(saeis_pkg::WAKE_HALT_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Sleep sequencer. A sleep instruction without sleep_enable is ignored.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      saeis_pkg::SAEIS_ST_RUN: begin
        if (sleep_instr_in && sleep_enable) begin
          state_nxt = saeis_pkg::SAEIS_ST_SLEEP; // R1
        end
      end
      saeis_pkg::SAEIS_ST_SLEEP: begin
        if (mode_r == saeis_pkg::SAEIS_MODE_IDLE) begin
          if (wake_idle) begin
            state_nxt = saeis_pkg::SAEIS_ST_HALT; // R12 R14
            cnt_nxt = halt_last;
          end
        end else if ((mode_r == saeis_pkg::SAEIS_MODE_PSAVE) ? wake_ps : wake_pd) begin
          state_nxt = saeis_pkg::SAEIS_ST_WAKE_DLY; // R15 R20
          cnt_nxt = wake_dly_cyc - saeis_pkg::CNT_W'(1);
        end
      end
      saeis_pkg::SAEIS_ST_WAKE_DLY: begin
        // The wake completes even if its cause has gone away meanwhile.
        if (cnt_r == '0) begin
          state_nxt = saeis_pkg::SAEIS_ST_HALT; // R18 R19
          cnt_nxt = halt_last;
        end else begin
          cnt_nxt = cnt_r - saeis_pkg::CNT_W'(1); // R18
        end
      end
      saeis_pkg::SAEIS_ST_HALT: begin
        if (cnt_r == '0) begin
          state_nxt = saeis_pkg::SAEIS_ST_RUN; // R12
        end else begin
          cnt_nxt = cnt_r - saeis_pkg::CNT_W'(1); // R12
        end
      end
      default: begin
        state_nxt = saeis_pkg::SAEIS_ST_RUN;
        cnt_nxt = '0;
      end
    endcase
  end

  // Clock gates follow the next state so that outputs change with the state register.
  // Only clocks are gated; no state is cleared, so memories keep their contents.
  wire saeis_pkg::saeis_mode_t mode_sel_hold = (state_r == saeis_pkg::SAEIS_ST_RUN) ? mode_sel : mode_r;
  wire next_asleep = (state_nxt == saeis_pkg::SAEIS_ST_SLEEP);
  wire next_mode_deep = (mode_sel_hold != saeis_pkg::SAEIS_MODE_IDLE);
  always_comb begin
    gate_nxt.cpu_clk_en = (state_nxt == saeis_pkg::SAEIS_ST_RUN); // R12 R13 R14
    gate_nxt.osc_en = !(next_asleep && next_mode_deep); // R15
    gate_nxt.periph_clk_en = gate_nxt.osc_en; // R14
    gate_nxt.t2_clk_en = gate_nxt.osc_en ||
      ((mode_sel_hold == saeis_pkg::SAEIS_MODE_PSAVE) && timer2_in.async_sel); // R20
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; reset (external or watchdog) returns to run and thus wakes.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mcu_control_r <= saeis_pkg::MCU_CTRL_RST;
      mcu_control_extended_r <= saeis_pkg::MCU_CTRL_EXT_RST;
      irq_mask_r <= saeis_pkg::IRQ_MASK_RST;
      irq_flag_r <= saeis_pkg::IRQ_FLAG_RST;
    end else if (ce_in) begin
      if (wr_ctrl) begin
        mcu_control_r <= reg_wdata_in;
      end
      if (wr_ctrl_ext) begin
        mcu_control_extended_r <= reg_wdata_in;
      end
      if (wr_mask) begin
        irq_mask_r <= reg_wdata_in[2:0];
      end
      irq_flag_r <= irq_flag_nxt;
    end
  end

  // Pin and oscillator samples plus level qualification.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_q_r <= 3'h7;
      wdt_q_r <= 1'b0;
      lvl_cnt_r <= 2'h0;
    end else if (ce_in) begin
      pin_q_r <= pin_now; // R6
      wdt_q_r <= wdt_osc_in;
      lvl_cnt_r <= lvl_cnt_nxt;
    end
  end

  // Sequencer state, mode latched at sleep entry.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r <= saeis_pkg::SAEIS_ST_RUN; // R13
      cnt_r <= '0;
      mode_r <= saeis_pkg::SAEIS_MODE_IDLE;
    end else if (ce_in) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      mode_r <= mode_sel_hold;
    end
  end

  wire [2:0] irq_flag_nxt_en = en_pend;

  // Registered outputs. Requests are held back until the CPU runs again, so a level
  // that went away during the wake delay never reaches the core.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
      irq_req_r <= 3'h0;
      sleeping_r <= 1'b0;
      gate_out <= '1;
    end else if (ce_in) begin
      rdata_r <= reg_rd_in ? rd_mux : 8'h00;
      irq_req_r <= (state_nxt == saeis_pkg::SAEIS_ST_RUN) ? irq_flag_nxt_en : 3'h0; // R8 R19
      sleeping_r <= (state_nxt != saeis_pkg::SAEIS_ST_RUN);
      gate_out <= gate_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign irq_req_out = irq_req_r;
  assign sleeping_out = sleeping_r;

endmodule

// ---- saeis_core_sva.sv ----
// Concurrent checks on the ports of the sleep and interrupt sense block.
// Assumes it is bound to saeis_core and sees only that module's ports.
`timescale 1ns/100ps
module saeis_core_sva (
  // Clock, reset and enable.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Register port.
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Core side and clock gates.
  input wire logic sleep_instr_in,
  input wire logic global_irq_en_in,
  input wire logic [2:0] irq_req_out,
  input wire logic sleeping_out,
  input wire saeis_pkg::saeis_t2_t timer2_in,
  input wire saeis_pkg::saeis_gate_t gate_out
);
  logic [7:0] ctl_r;
  logic [7:0] ext_r;
  logic [2:0] mask_r;

  // Shadow copies of the written registers, so that entry checks know the selected mode.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctl_r <= 8'h00;
      ext_r <= 8'h00;
      mask_r <= 3'h0;
    end else if (ce_in && reg_wr_in) begin
      if (reg_addr_in == saeis_pkg::MCU_CTRL_OFS) ctl_r <= reg_wdata_in;
      if (reg_addr_in == saeis_pkg::MCU_CTRL_EXT_OFS) ext_r <= reg_wdata_in;
      if (reg_addr_in == saeis_pkg::IRQ_MASK_OFS) mask_r <= reg_wdata_in[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // A sleep instruction that the sequencer accepts.
  sequence s_take;
    ce_in && sleep_instr_in && !sleeping_out && ctl_r[5];
  endsequence

  a_sleep_refused: assert property (ce_in && sleep_instr_in && !sleeping_out && !ctl_r[5] |=> !sleeping_out)
    else $error("sleep entered with sleep enable clear");
  a_sleep_entry: assert property (s_take |=> sleeping_out && !gate_out.cpu_clk_en)
    else $error("accepted sleep did not stop the cpu clock");
  a_idle_clocks: assert property (s_take ##0 !ctl_r[4] |=> gate_out.osc_en && gate_out.periph_clk_en)
    else $error("idle entry stopped oscillator or peripherals");
  a_pdown_clocks: assert property (s_take ##0 ctl_r[4] |=> !gate_out.osc_en && !gate_out.periph_clk_en)
    else $error("power-down entry left oscillator running");
  a_psave_timer: assert property (s_take ##0 ctl_r[4] && ext_r[7] && timer2_in.async_sel |=> gate_out.t2_clk_en)
    else $error("power-save stopped the async timer clock");
  a_halt_four: assert property ($fell(sleeping_out) |-> gate_out.cpu_clk_en && !$past(gate_out.cpu_clk_en, 4))
    else $error("wake did not halt the cpu for four cycles");
  a_irq_global: assert property (ce_in && !global_irq_en_in |=> irq_req_out == 3'h0)
    else $error("request raised with global flag clear");
  a_irq_mask: assert property (ce_in |=> (irq_req_out & ~$past(mask_r)) == 3'h0)
    else $error("request raised on a masked pin");
  a_reset_wakes: assert property ($fell(rst_in) |-> !sleeping_out && gate_out == 4'hF)
    else $error("reset did not wake the device");
  a_ctl_readback: assert property (ce_in && reg_rd_in && reg_addr_in == saeis_pkg::MCU_CTRL_OFS |=> reg_rdata_out == ctl_r)
    else $error("control register read back wrong");
endmodule

bind saeis_core saeis_core_sva chk_u (.clk_sys_in, .rst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .sleep_instr_in, .global_irq_en_in, .irq_req_out, .sleeping_out, .timer2_in, .gate_out);

// ---- saeis_core_model.sv ----
// Behavioural model of the processor core and the watchdog oscillator.
// Assumes the testbench clock and reset; outputs change just after a rising edge.
`timescale 1ns/100ps
module saeis_core_model #(
  parameter int WDT_HALF = 4
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Requests and gate from the block, acknowledge switch from the bench.
  input wire logic [2:0] irq_req_in,
  input wire logic cpu_run_in,
  input wire logic ack_on_in,
  // Answers to the block.
  output logic [2:0] irq_ack_out,
  output logic wdt_osc_out
);
  int cnt_r;

  // Watchdog oscillator, shortened so that level wake-up stays cheap to simulate.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || cnt_r == WDT_HALF - 1) begin
      cnt_r <= 0;
      wdt_osc_out <= rst_in ? 1'b0 : ~wdt_osc_out;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end

  // The core enters a vector only while its clock runs, pulsing on alternate cycles while a request stays high.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) irq_ack_out <= 3'h0;
    else irq_ack_out <= (ack_on_in && cpu_run_in) ? (irq_req_in & ~irq_ack_out) : 3'h0;
  end
endmodule

// ---- saeis_core_tb_top.sv ----
// Self-checking testbench for the sleep sequencer and external interrupt sense block.
// Assumes saeis_core, its checker and the core model are compiled beforehand.
`timescale 1ns/100ps
module saeis_core_tb_top;
  localparam int WAKE_UNIT = 4;
  localparam logic [3:0] EXP_LO = 4'h7;
  localparam logic [3:0] EXP_HI = 4'hE;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep_instr = 1'b0;
  logic glob = 1'b1;
  logic ack_on = 1'b0;
  logic [2:0] pins = 3'h7;
  logic [3:0] fuses = 4'h1;
  saeis_pkg::saeis_t2_t t2 = 5'h00;
  logic [7:0] rdata;
  logic [2:0] irq_req;
  logic [2:0] irq_ack;
  logic sleeping;
  logic wdt;
  saeis_pkg::saeis_gate_t gate;
  int errors = 0;
  int cmp_count = 0;
  int n;

  // Clock at 250 MHz.
  always #2 clk_sys_in = ~clk_sys_in;

  saeis_core #(.WAKE_UNIT_CYC(WAKE_UNIT)) dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .sleep_instr_in(sleep_instr), .global_irq_en_in(glob), .irq_ack_in(irq_ack), .periph_irq_in(1'b0),
    .irq_req_out(irq_req), .sleeping_out(sleeping), .ext_irq_pin_a_in(pins[0]), .ext_irq_pin_b_in(pins[1]),
    .ext_irq_pin_c_in(pins[2]), .wdt_osc_in(wdt), .clock_select_fuses_in(fuses), .timer2_in(t2), .gate_out(gate));
  saeis_core_model #(.WDT_HALF(4)) core_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .irq_req_in(irq_req),
    .cpu_run_in(gate.cpu_clk_en), .ack_on_in(ack_on), .irq_ack_out(irq_ack), .wdt_osc_out(wdt));

  ////////////////////////////////////////////////////////////////////////////
  // Shared comparison and bus tasks; every drive lands by non-blocking assignment on an edge.
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic set_pin(input int p, input logic v);
    @(posedge clk_sys_in);
    pins[p] <= v;
  endtask
  // Sleep enable is written right before the instruction, so no stale enable can put it to sleep.
  task automatic do_sleep(input logic [7:0] ctl);
    wr_reg(saeis_pkg::MCU_CTRL_OFS, ctl);
    @(posedge clk_sys_in);
    sleep_instr <= 1'b1;
    @(posedge clk_sys_in);
    sleep_instr <= 1'b0;
    #1;
  endtask
  task automatic wait_wake(input int lim);
    n = 0;
    while (sleeping !== 1'b0 && n < lim) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog; the tests need about four hundred cycles.
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd_reg(saeis_pkg::MCU_CTRL_OFS, 8'h00, "ctl reset");
    rd_reg(saeis_pkg::MCU_CTRL_EXT_OFS, 8'h00, "ext reset");
    wr_reg(8'h99, 8'hFF);
    rd_reg(8'h99, 8'h00, "unmapped");
    wr_reg(saeis_pkg::MCU_CTRL_EXT_OFS, 8'hA5);
    rd_reg(saeis_pkg::MCU_CTRL_EXT_OFS, 8'hA5, "ext rw");
    wr_reg(saeis_pkg::MCU_CTRL_EXT_OFS, 8'h00);
    wr_reg(saeis_pkg::IRQ_MASK_OFS, 8'h07);
    // Every sense code on pins a and b; the low phase is held long enough to be seen.
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        wr_reg(saeis_pkg::MCU_CTRL_OFS, 8'(m << (2 * p)));
        set_pin(p, 1'b0);
        cyc(4);
        chk("req low", {7'h00, irq_req[p]}, {7'h00, EXP_LO[m]});
        set_pin(p, 1'b1);
        cyc(4);
        chk("req high", {7'h00, irq_req[p]}, {7'h00, EXP_HI[m]});
        wr_reg(saeis_pkg::IRQ_FLAG_OFS, 8'h07);
      end
    end
    // Pin c, both edge selects, changed under mask with the flag cleared afterwards.
    for (int e = 0; e < 2; e++) begin
      wr_reg(saeis_pkg::IRQ_MASK_OFS, 8'h03);
      wr_reg(saeis_pkg::MCU_CTRL_EXT_OFS, 8'(e));
      wr_reg(saeis_pkg::IRQ_FLAG_OFS, 8'h04);
      wr_reg(saeis_pkg::IRQ_MASK_OFS, 8'h07);
      set_pin(2, 1'b0);
      cyc(13);
      chk("c first", {7'h00, irq_req[2]}, {7'h00, e == 0});
      set_pin(2, 1'b1);
      cyc(4);
      chk("c second", {7'h00, irq_req[2]}, 8'h01);
      wr_reg(saeis_pkg::IRQ_FLAG_OFS, 8'h04);
    end
    // Global flag and mask gate a latched falling-edge request.
    wr_reg(saeis_pkg::MCU_CTRL_OFS, 8'h02);
    @(posedge clk_sys_in) glob <= 1'b0;
    set_pin(0, 1'b0);
    cyc(2);
    set_pin(0, 1'b1);
    cyc(4);
    chk("no global", {7'h00, irq_req[0]}, 8'h00);
    wr_reg(saeis_pkg::IRQ_MASK_OFS, 8'h06);
    @(posedge clk_sys_in) glob <= 1'b1;
    cyc(3);
    chk("masked", {7'h00, irq_req[0]}, 8'h00);
    wr_reg(saeis_pkg::IRQ_MASK_OFS, 8'h07);
    cyc(3);
    chk("unmasked", {7'h00, irq_req[0]}, 8'h01);
    wr_reg(saeis_pkg::IRQ_FLAG_OFS, 8'h07);
    // Refused sleep, then idle through the reserved code, woken by pin a and acknowledged.
    do_sleep(8'h02);
    chk("no sleep", {7'h00, sleeping}, 8'h00);
    wr_reg(saeis_pkg::MCU_CTRL_EXT_OFS, 8'h80);
    do_sleep(8'h22);
    chk("idle gates", {3'h0, sleeping, gate}, 8'h17);
    set_pin(0, 1'b0);
    wait_wake(40);
    chk("idle wake", {6'h00, irq_req[0], sleeping}, 8'h02);
    set_pin(0, 1'b1);
    @(posedge clk_sys_in) ack_on <= 1'b1;
    cyc(4);
    chk("acked", {7'h00, irq_req[0]}, 8'h00);
    @(posedge clk_sys_in) ack_on <= 1'b0;
    // Power-down: one watchdog sample is not enough, two are; the level goes before the delay ends.
    wr_reg(saeis_pkg::MCU_CTRL_EXT_OFS, 8'h00);
    wr_reg(saeis_pkg::IRQ_FLAG_OFS, 8'h07);
    do_sleep(8'h30);
    chk("pdown gates", {5'h00, gate[3:1]}, 8'h00);
    @(negedge wdt) set_pin(1, 1'b0);
    @(negedge wdt) set_pin(1, 1'b1);
    repeat (3) @(negedge wdt);
    #1;
    chk("one sample", {7'h00, sleeping}, 8'h01);
    @(negedge wdt) set_pin(1, 1'b0);
    n = 0;
    while (gate.osc_en !== 1'b1 && n < 40) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    set_pin(1, 1'b1);
    wait_wake(60);
    chk("wake delay", {7'h00, 1'(n + 1 >= WAKE_UNIT * (fuses + 1) + 4 && n < WAKE_UNIT * (fuses + 1) + 7)}, 8'h01);
    chk("vanished", {6'h00, irq_req[1], sleeping}, 8'h00);
    // Power-save with the timer on its own clock, woken by an enabled overflow.
    @(posedge clk_sys_in) t2 <= 5'h10;
    wr_reg(saeis_pkg::MCU_CTRL_EXT_OFS, 8'h80);
    do_sleep(8'h30);
    chk("psave gates", {4'h0, gate}, 8'h01);
    @(posedge clk_sys_in) t2 <= 5'h1C;
    wait_wake(80);
    chk("psave wake", {7'h00, sleeping}, 8'h00);
    @(posedge clk_sys_in) t2 <= 5'h00;
    // A single-cycle pin c pulse in power-down is held until the wake completes.
    wr_reg(saeis_pkg::MCU_CTRL_EXT_OFS, 8'h00);
    do_sleep(8'h30);
    set_pin(2, 1'b0);
    set_pin(2, 1'b1);
    wait_wake(80);
    cyc(2);
    chk("c wake", {6'h00, irq_req[2], sleeping}, 8'h02);
    wr_reg(saeis_pkg::IRQ_FLAG_OFS, 8'h07);
    // Reset in the middle of idle sleep.
    do_sleep(8'h20);
    @(posedge clk_sys_in) rst_in <= 1'b1;
    cyc(2);
    @(posedge clk_sys_in) rst_in <= 1'b0;
    cyc(1);
    chk("reset wake", {3'h0, sleeping, gate}, 8'h0F);
    rd_reg(saeis_pkg::MCU_CTRL_OFS, 8'h00, "ctl after reset");
    give_verdict();
  end
endmodule
